/* ltr_pkg.sv */
// Package with constants, register map and types of the line heat guard.
`default_nettype none
package ltr_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_PERIOD_US = 1000;
  localparam int STEP_CYCLES = STEP_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int STEPS_PER_MIN = 60000;
  localparam int RMS_WINDOW = 20;
  localparam int COUNTS_PER_PCT = 100;
  localparam int FRAC_BITS = 32;
  localparam int PCT_SCALE = 100;
  localparam logic [63:0] ONE_PCT_FIX = 64'h0000_0000_028f_5c29;
  localparam logic [63:0] RATIO_MAX = 64'h0000_0fff_ffff_ffff;
  localparam logic signed [15:0] TEMP_MAX = 16'sh7fff;
  localparam logic [9:0] TAU_MIN_LEGAL = 10'h001;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ALARM = 12'h004;
  localparam logic [11:0] ADDR_TRIP = 12'h008;
  localparam logic [11:0] ADDR_RATED = 12'h00c;
  localparam logic [11:0] ADDR_BASE = 12'h010;
  localparam logic [11:0] ADDR_UNLOCK = 12'h014;
  localparam logic [11:0] ADDR_AMBIENT = 12'h018;
  localparam logic [11:0] ADDR_STARTUP = 12'h01c;
  localparam logic [11:0] ADDR_INOM = 12'h020;
  localparam logic [11:0] ADDR_TAU = 12'h024;
  localparam logic [11:0] ADDR_STATUS = 12'h028;
  localparam logic [11:0] ADDR_TEMP = 12'h02c;
  localparam logic [11:0] ADDR_RMS_A = 12'h030;
  localparam logic [11:0] ADDR_RMS_B = 12'h034;
  localparam logic [11:0] ADDR_RMS_C = 12'h038;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h03c;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h040;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h044;

  localparam int CTRL_SENS_BIT = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {
    LTR_MODE_OFF = 2'b00,
    LTR_MODE_PULSED = 2'b01,
    LTR_MODE_LOCKED = 2'b10
  } ltr_mode_type;

  typedef enum logic [1:0] {
    TRIP_IDLE = 2'b00,
    TRIP_PULSE = 2'b01,
    TRIP_REARM = 2'b10,
    TRIP_LATCH = 2'b11
  } ltr_trip_state_type;

  typedef struct packed {
    logic [1:0] mode;
    logic sens_sel;
    logic [7:0] alarm_temp;
    logic [7:0] trip_temp;
    logic [7:0] rated_temp;
    logic [7:0] base_temp;
    logic [7:0] unlock_temp;
    logic [7:0] ambient_temp_setting;
    logic [7:0] startup_pct;
    logic [7:0] inom_pct;
    logic [9:0] tau_min;
  } ltr_cfg_type;

  typedef struct packed {
    logic restart_block;
    logic trip;
    logic alarm;
  } ltr_flags_type;

  localparam ltr_cfg_type CFG_RST = '{
    mode: 2'h1, sens_sel: 1'b0, alarm_temp: 8'h50, trip_temp: 8'h64,
    rated_temp: 8'h64, base_temp: 8'h19, unlock_temp: 8'h3c,
    ambient_temp_setting: 8'h19, startup_pct: 8'h00, inom_pct: 8'h64,
    tau_min: 10'h00a};
endpackage : ltr_pkg
`default_nettype wire

/* ltr_line_heat_guard.sv */
// Line thermal replica with RMS front end, trip logic and APB registers.
`default_nettype none
module ltr_line_heat_guard #(
  parameter int STEP_CYCLES_P = ltr_pkg::STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0][15:0] phase_current,
  input wire logic [7:0] ambient_sensor,
  input wire logic block_in,
  input wire logic reload_in,
  output ltr_pkg::ltr_flags_type flags,
  output logic irq
);
  import ltr_pkg::*;

  function automatic logic [15:0] ltr_isqrt(input logic [31:0] v);
    logic [15:0] r;
    logic [15:0] trial;
    r = '0;
    for (int i = 15; i >= 0; i--) begin
      trial = r | (16'h0001 << i);
      if (32'(trial) * 32'(trial) <= v) begin
        r = trial;
      end
    end
    return r;
  endfunction : ltr_isqrt

  logic [9:0] sync1;
  logic [9:0] sync2;
  logic block_sync;
  logic reload_sync;
  logic [7:0] amb_sync;

  // The sensor word crosses on plain double flops; a slowly moving
  // temperature tolerates a rare one-cycle mix of old and new bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {block_in, reload_in, ambient_sensor};
      sync2 <= sync1;
    end
  end
  assign block_sync = sync2[9];
  assign reload_sync = sync2[8];
  assign amb_sync = sync2[7:0];

  logic [15:0] step_cnt;
  logic [15:0] next_step_cnt;
  logic step_tick;
  assign step_tick = step_cnt == 16'(STEP_CYCLES_P - 1);
  always_comb begin
    next_step_cnt = step_tick ? '0 : step_cnt + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= next_step_cnt;
    end
  end

  logic [2:0][39:0] sq_sum;
  logic [2:0][39:0] next_sq_sum;
  logic [2:0][15:0] rms;
  logic [2:0][15:0] next_rms;
  logic [4:0] win_cnt;
  logic [4:0] next_win_cnt;
  always_comb begin
    logic [31:0] square;
    logic [39:0] acc;
    square = '0;
    acc = '0;
    next_sq_sum = sq_sum;
    next_rms = rms;
    next_win_cnt = win_cnt;
    if (step_tick) begin
      next_win_cnt = (win_cnt == 5'(RMS_WINDOW - 1)) ? '0 : win_cnt + 5'h01;
      for (int p = 0; p < 3; p++) begin
        square = 32'($signed(phase_current[p])) *
                 32'($signed(phase_current[p]));
        acc = sq_sum[p] + 40'(square);
        if (win_cnt == 5'(RMS_WINDOW - 1)) begin
          next_rms[p] = ltr_isqrt(32'(acc / 40'(RMS_WINDOW)));
          next_sq_sum[p] = '0;
        end else begin
          next_sq_sum[p] = acc;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_sum <= '0;
      rms <= '0;
      win_cnt <= '0;
    end else begin
      sq_sum <= next_sq_sum;
      rms <= next_rms;
      win_cnt <= next_win_cnt;
    end
  end

  ltr_cfg_type cfg;
  ltr_cfg_type next_cfg;
  logic signed [47:0] level;
  logic signed [47:0] next_level;
  logic init_pending;
  logic [15:0] rms_max;
  logic signed [15:0] temp;
  logic [15:0] level_pct;
  logic [7:0] rated_rise;
  logic [7:0] ambient;
  logic [15:0] in_cnt;
  logic [31:0] in_sq;
  logic [31:0] rms_sq;
  logic [63:0] quot;
  logic [63:0] ratio;
  logic [9:0] tau_eff;
  logic signed [63:0] tau_s;
  logic signed [63:0] diff;
  logic signed [63:0] delta;
  logic signed [63:0] prod;
  logic signed [63:0] temp_wide;
  always_comb begin
    rms_max = rms[0];
    for (int p = 1; p < 3; p++) begin
      if (rms[p] > rms_max) begin
        rms_max = rms[p];
      end
    end
    rated_rise = (cfg.rated_temp > cfg.base_temp) ?
                 cfg.rated_temp - cfg.base_temp : 8'h00;
    ambient = cfg.sens_sel ? amb_sync : cfg.ambient_temp_setting;
    in_cnt = 16'(cfg.inom_pct * COUNTS_PER_PCT);
    in_sq = 32'(in_cnt) * 32'(in_cnt);
    rms_sq = 32'(rms_max) * 32'(rms_max);
    quot = (in_sq == '0) ? RATIO_MAX : {rms_sq, 32'h0000_0000} / 64'(in_sq);
    ratio = (quot > RATIO_MAX) ? RATIO_MAX : quot;
    tau_eff = (cfg.tau_min < TAU_MIN_LEGAL) ? TAU_MIN_LEGAL : cfg.tau_min;
    tau_s = $signed(64'(tau_eff) * 64'(STEPS_PER_MIN));
    diff = $signed(ratio) - 64'(level);
    delta = diff / tau_s;
    if (init_pending || reload_sync) begin
      next_level = 48'(64'(cfg.startup_pct) * ONE_PCT_FIX);
    end else if (step_tick) begin
      next_level = 48'(64'(level) + delta);
    end else begin
      next_level = level;
    end
    prod = 64'(level) * $signed(64'(rated_rise));
    temp_wide = (prod >>> FRAC_BITS) + $signed(64'(ambient));
    temp = (temp_wide > 64'(TEMP_MAX)) ? TEMP_MAX : 16'(temp_wide);
    level_pct = 16'((64'(level) * 64'(PCT_SCALE)) >>> FRAC_BITS);
  end
  // The model keeps integrating while off or blocked so that the heat
  // memory of the line is not lost when the function is re-enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
      init_pending <= 1'b1;
    end else begin
      level <= next_level;
      init_pending <= 1'b0;
    end
  end

  ltr_trip_state_type trip_state;
  ltr_trip_state_type next_trip_state;
  ltr_flags_type next_flags;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] next_irq_enable;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic active;
  logic over_trip;
  assign active = (cfg.mode == LTR_MODE_PULSED ||
                   cfg.mode == LTR_MODE_LOCKED) && !block_sync;
  assign over_trip = temp > $signed({8'h00, cfg.trip_temp});

  always_comb begin
    next_trip_state = trip_state;
    if (!active) begin
      next_trip_state = TRIP_IDLE;
    end else if (step_tick) begin
      case (trip_state)
        TRIP_IDLE: begin
          if (over_trip && cfg.mode == LTR_MODE_LOCKED) begin
            next_trip_state = TRIP_LATCH;
          end else if (over_trip) begin
            next_trip_state = TRIP_PULSE;
          end
        end
        TRIP_PULSE: begin
          next_trip_state = over_trip ? TRIP_REARM : TRIP_IDLE;
        end
        TRIP_REARM: begin
          if (!over_trip) begin
            next_trip_state = TRIP_IDLE;
          end
        end
        TRIP_LATCH: begin
          if (temp < $signed({8'h00, cfg.unlock_temp})) begin
            next_trip_state = TRIP_IDLE;
          end else if (cfg.mode != LTR_MODE_LOCKED) begin
            next_trip_state = TRIP_REARM;
          end
        end
        default: begin
          next_trip_state = TRIP_IDLE;
        end
      endcase
    end
    next_flags.alarm = active &&
                       temp > $signed({8'h00, cfg.alarm_temp});
    next_flags.trip = next_trip_state == TRIP_PULSE ||
                      next_trip_state == TRIP_LATCH;
    next_flags.restart_block = active &&
                       temp > $signed({8'h00, cfg.unlock_temp});
  end

  // APB slave with no wait states; read data is latched in the setup
  // cycle so that prdata comes straight from a flop in the access cycle.
  assign pready = 1'b1;
  always_comb begin
    logic [IRQ_W-1:0] clr;
    logic wr;
    clr = '0;
    wr = psel && penable && pwrite;
    next_cfg = cfg;
    next_irq_enable = irq_enable;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_pslverr = 1'b0;
      case (paddr)
        ADDR_CTRL: next_prdata = 32'({cfg.sens_sel, cfg.mode});
        ADDR_ALARM: next_prdata = 32'(cfg.alarm_temp);
        ADDR_TRIP: next_prdata = 32'(cfg.trip_temp);
        ADDR_RATED: next_prdata = 32'(cfg.rated_temp);
        ADDR_BASE: next_prdata = 32'(cfg.base_temp);
        ADDR_UNLOCK: next_prdata = 32'(cfg.unlock_temp);
        ADDR_AMBIENT: next_prdata = 32'(cfg.ambient_temp_setting);
        ADDR_STARTUP: next_prdata = 32'(cfg.startup_pct);
        ADDR_INOM: next_prdata = 32'(cfg.inom_pct);
        ADDR_TAU: next_prdata = 32'(cfg.tau_min);
        ADDR_STATUS: next_prdata = 32'({block_sync, flags});
        ADDR_TEMP: next_prdata = {level_pct, temp};
        ADDR_RMS_A: next_prdata = 32'(rms[0]);
        ADDR_RMS_B: next_prdata = 32'(rms[1]);
        ADDR_RMS_C: next_prdata = 32'(rms[2]);
        ADDR_IRQ_STATUS: next_prdata = 32'(irq_status);
        ADDR_IRQ_CLEAR: next_prdata = '0;
        ADDR_IRQ_ENABLE: next_prdata = 32'(irq_enable);
        default: begin
          next_prdata = '0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          next_cfg.mode = pwdata[1:0];
          next_cfg.sens_sel = pwdata[CTRL_SENS_BIT];
        end
        ADDR_ALARM: next_cfg.alarm_temp = pwdata[7:0];
        ADDR_TRIP: next_cfg.trip_temp = pwdata[7:0];
        ADDR_RATED: next_cfg.rated_temp = pwdata[7:0];
        ADDR_BASE: next_cfg.base_temp = pwdata[7:0];
        ADDR_UNLOCK: next_cfg.unlock_temp = pwdata[7:0];
        ADDR_AMBIENT: next_cfg.ambient_temp_setting = pwdata[7:0];
        ADDR_STARTUP: next_cfg.startup_pct = pwdata[7:0];
        ADDR_INOM: next_cfg.inom_pct = pwdata[7:0];
        ADDR_TAU: next_cfg.tau_min = pwdata[9:0];
        ADDR_IRQ_CLEAR: clr = pwdata[IRQ_W-1:0];
        ADDR_IRQ_ENABLE: next_irq_enable = pwdata[IRQ_W-1:0];
        default: clr = '0;
      endcase
    end
    // A new rising edge wins over a clear written in the same cycle.
    next_irq_status = (irq_status & ~clr) | (next_flags & ~flags);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RST;
      trip_state <= TRIP_IDLE;
      flags <= '0;
      irq_status <= '0;
      irq_enable <= '0;
      prdata <= '0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      trip_state <= next_trip_state;
      flags <= next_flags;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      irq <= |(next_irq_status & next_irq_enable);
    end
  end
endmodule : ltr_line_heat_guard
`default_nettype wire

/* ltr_props.sv */
// Port checker for the line heat guard.
`default_nettype none
module ltr_props #(
  parameter int STEP_CYCLES_P = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic block_in,
  input wire ltr_pkg::ltr_flags_type flags,
  input wire logic irq
);
  import ltr_pkg::*;
  int ph;
  int hi;
  int quiet;
  logic seen;
  wire logic wr = psel && penable && pwrite;
  // Trip edges sit whole steps apart unless a write or block forces it off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 0;
      hi <= 0;
      quiet <= 0;
      seen <= 1'b0;
    end else begin
      ph <= $rose(flags.trip) ? 1 : (ph + 1) % STEP_CYCLES_P;
      hi <= flags.trip ? hi + 1 : 0;
      quiet <= (wr || block_in) ? 0 : quiet + 1;
      seen <= seen || $rose(flags.trip);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_block_clears;
    block_in [*4] |-> flags == 3'b000;
  endproperty
  a_block_clears: assert property (p_block_clears)
    else $error("flags set while blocked");
  property p_block_release;
    block_in [*5] ##1 !block_in |-> flags == 3'b000 ##1 flags == 3'b000;
  endproperty
  a_block_release: assert property (p_block_release)
    else $error("flags back too early after block");
  property p_trip_on_tick;
    $rose(flags.trip) && seen |-> ph == 0;
  endproperty
  a_trip_on_tick: assert property (p_trip_on_tick)
    else $error("trip rose off the step grid");
  property p_trip_whole;
    $fell(flags.trip) && quiet > 4 |-> hi % STEP_CYCLES_P == 0;
  endproperty
  a_trip_whole: assert property (p_trip_whole)
    else $error("trip length not whole steps");
  property p_irq_cause;
    $rose(irq) |-> (flags & ~$past(flags)) != 3'b000 || $past(wr) ||
      ($past(flags) & ~$past(flags, 2)) != 3'b000 || $past(wr, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without cause");
  property p_prdata_hold;
    psel && penable |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data moved after access");
  property p_no_err_mapped;
    psel && penable && paddr <= ADDR_IRQ_ENABLE && paddr[1:0] == 2'b00
      |-> !pslverr;
  endproperty
  a_no_err_mapped: assert property (p_no_err_mapped)
    else $error("error on mapped address");
  property p_reset_quiet;
    $rose(presetn) |-> flags == 3'b000 && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active at reset release");
  c_trip: cover property ($rose(flags.trip));
  c_trip_end: cover property ($fell(flags.trip) && quiet > 4);
  c_irq: cover property ($rose(irq));
  c_err: cover property (psel && penable && pslverr);
endmodule : ltr_props
`default_nettype wire

/* ltr_line_source.sv */
// Line side model: phase current source and trip relay monitor.
`default_nettype none
module ltr_line_source (
  input wire logic pclk,
  input wire logic [2:0][15:0] amp,
  input wire logic trip,
  output logic [2:0][15:0] phase_current,
  output int pulses,
  output int width
);
  logic neg = 1'b0;
  int run = 0;
  int pulse_cnt = 0;
  int last_width = 0;
  assign pulses = pulse_cnt;
  assign width = last_width;
  // The sign flips every cycle, so only a true RMS returns the amplitude.
  always @(posedge pclk) begin
    neg <= !neg;
    run <= trip ? run + 1 : 0;
    if (!trip && run > 0) begin
      pulse_cnt <= pulse_cnt + 1;
      last_width <= run;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      phase_current[i] = neg ? -amp[i] : amp[i];
    end
  end
endmodule : ltr_line_source
`default_nettype wire

/* tb.sv */
// Self-checking bench for the line heat guard.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ltr_pkg::*;
  localparam int SC = 21;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0][15:0] amp;
  logic [2:0][15:0] phase_current;
  logic [7:0] ambient_sensor = 8'h00;
  logic block_in = 1'b0;
  logic reload_in = 1'b0;
  ltr_flags_type flags;
  logic irq;
  int pulses, width, fail_count = 0, comparisons = 0;
  logic [31:0] seed = 32'h0000_000f;
  logic [31:0] r;
  logic [7:0] t;
  logic [64:0] ex;
  logic [64:0] exp_q[$];
  always #25 pclk = !pclk;
  ltr_line_heat_guard #(.STEP_CYCLES_P(SC)) i_ltr_line_heat_guard (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .phase_current, .ambient_sensor, .block_in, .reload_in,
    .flags, .irq);
  ltr_line_source i_ltr_line_source (.pclk, .amp, .trip(flags.trip),
    .phase_current, .pulses, .width);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic bad(input string s);
    fail_count++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : bad
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    comparisons++;
    if (got !== e) bad($sformatf("got %h expected %h", got, e));
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back({e, m, d & m});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      bad("no ready");
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr
  task automatic steps(input int k);
    repeat (k * SC) @(posedge pclk);
    @(negedge pclk);
  endtask : steps
  task automatic until_trip();
    int n;
    n = 0;
    while (flags.trip !== 1'b1 && n < 4 * SC) begin
      @(negedge pclk);
      n++;
    end
    if (n == 4 * SC) begin
      bad("trip wait ran out");
      summarize();
    end
  endtask : until_trip
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      ex = exp_q.pop_front();
      comparisons++;
      if ((prdata & ex[63:32]) !== ex[31:0] || pslverr !== ex[64])
        bad($sformatf("read %h gave %h", paddr, prdata));
    end
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      amp[i] = {3'b000, r[12:0]};
    end
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h1, '1, 1'b0);
    apb(1'b0, ADDR_TRIP, 32'h64, '1, 1'b0);
    apb(1'b0, ADDR_IRQ_ENABLE, 32'h0, '1, 1'b0);
    apb(1'b0, 12'h100, 32'h0, '1, 1'b1);
    steps(1);
    chk(flags, 32'h0);
    wr(ADDR_RATED, 32'h7d);
    wr(ADDR_AMBIENT, 32'h18);
    wr(ADDR_STARTUP, 32'h3d);
    wr(ADDR_IRQ_ENABLE, 32'h7);
    @(posedge pclk);
    reload_in <= 1'b1;
    repeat (4) @(posedge pclk);
    reload_in <= 1'b0;
    steps(1);
    chk(flags, 32'h5);
    apb(1'b0, ADDR_TEMP, 32'h003c_0054, 32'hfffe_fffe, 1'b0);
    wr(ADDR_TRIP, 32'h50);
    until_trip();
    steps(3);
    chk(flags, 32'h5);
    chk(width, SC);
    chk(irq, 32'h1);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h7, '1, 1'b0);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, '1, 1'b0);
    wr(ADDR_TRIP, 32'h64);
    steps(2);
    wr(ADDR_TRIP, 32'h50);
    until_trip();
    steps(2);
    chk(pulses, 32'h2);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    steps(1);
    chk(flags, 32'h0);
    chk(irq, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    steps(1);
    chk(flags, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    until_trip();
    wr(ADDR_TRIP, 32'h64);
    steps(3);
    chk(flags, 32'h7);
    wr(ADDR_UNLOCK, 32'h5a);
    steps(2);
    chk(flags, 32'h1);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h7, '1, 1'b0);
    @(posedge pclk);
    block_in <= 1'b1;
    steps(1);
    chk(flags, 32'h0);
    @(posedge pclk);
    block_in <= 1'b0;
    steps(1);
    chk(flags, 32'h1);
    r = rnd();
    t = {3'b000, r[4:1], 1'b0};
    @(posedge pclk);
    ambient_sensor <= t;
    wr(ADDR_CTRL, 32'h6);
    steps(1);
    apb(1'b0, ADDR_TEMP, {24'h003c00, 8'h3c + t}, 32'hfffe_fffe, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ADDR_RMS_A + 12'(4 * i), {16'h0, amp[i]}, '1, 1'b0);
    end
    steps(1);
    summarize();
  end
endmodule : tb
bind ltr_line_heat_guard ltr_props #(.STEP_CYCLES_P(STEP_CYCLES_P))
  i_ltr_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .block_in, .flags, .irq);
`default_nettype wire
